// File: sci_pkg.sv
// Shared constants and types for the strap, indicator and mode logic.
// Assumes a single 100 MHz clock and a plain register port.
package sci_pkg;

  // Operating modes as read from the rotary selector
  typedef enum logic [1:0] {
    SCI_MODE_RUN,
    SCI_MODE_STOP,
    SCI_MODE_RESET,
    SCI_MODE_PROGRAM
  } sci_mode_e;

  // Synchronised board straps, one bit each unless noted
  typedef struct packed {
    logic retention_strap;   // Fitted: keep all flags, timers, counters
    logic time_base_strap;   // Fitted: 0.1 s tick, removed: 0.01 s
    logic dblock_vol_strap;  // Fitted: all data blocks volatile
    logic [1:0] area_sel;    // Share of text/data space on data socket
    logic write_en_strap;    // Fitted: program and text sockets writable
    logic upper_on_data;     // Upper program lines on data socket
  } sci_straps_s;

  // Memory write strobes from the processor
  typedef struct packed {
    logic program_memory_socket;
    logic text_socket;
    logic data_socket;
    logic legacy_ram;
  } sci_wr_s;

  // Clock and timing
  localparam int SCI_CLK_HZ = 100_000_000;
  localparam int SCI_TICK_SLOW_MS = 100;   // 1/10 s time base
  localparam int SCI_TICK_FAST_MS = 10;    // 1/100 s time base
  localparam int SCI_TICK_SLOW_CYC = SCI_CLK_HZ / 1000 * SCI_TICK_SLOW_MS;
  localparam int SCI_TICK_FAST_CYC = SCI_CLK_HZ / 1000 * SCI_TICK_FAST_MS;
  localparam int SCI_LED_TICKS = 20;        // Ticks between lamp toggles
  localparam int SCI_TICK_W = 24;

  // Element addresses
  localparam logic [9:0] SCI_RETAIN_LO = 10'd765;
  localparam logic [9:0] SCI_RETAIN_HI = 10'd999;
  localparam int SCI_DATA_BLOCKS = 32;

  // Memory map
  localparam logic [12:0] SCI_UPPER_PROGRAM_MEMORY_SOCKET_BASE = 13'h1000; // Line 4096
  localparam logic [13:0] SCI_AREA_NONE = 14'h2000;
  localparam logic [13:0] SCI_AREA_QUARTER = 14'h1800;
  localparam logic [13:0] SCI_AREA_HALF = 14'h1000;
  localparam logic [13:0] SCI_AREA_ALL = 14'h0000;
  localparam logic [1:0] SCI_SOCK_PROGRAM = 2'h0;
  localparam logic [1:0] SCI_SOCK_TEXT = 2'h1;
  localparam logic [1:0] SCI_SOCK_DATA = 2'h2;

  // Register offsets
  localparam logic [3:0] SCI_REG_CTRL = 4'h0;
  localparam logic [3:0] SCI_REG_STATUS = 4'h4;
  localparam logic [3:0] SCI_REG_TICKS = 4'h8;

  // Control fields
  localparam int SCI_CTRL_HALT_BIT = 0;
  localparam int SCI_CTRL_ERRCLR_BIT = 1;

  // Reset values
  localparam logic SCI_CTRL_HALT_RST = 1'b0;
  localparam logic SCI_LED_RST = 1'b0;
  localparam logic [10:0] SCI_PIN_RST = 11'h000;
  localparam logic SCI_TB_SLOW_RST = 1'b1;
  localparam logic SCI_DBLOCK_VOL_RST = 1'b1;

endpackage : sci_pkg

// File: sci_strap_ctrl.sv
// Strap, write gating, mode and indicator logic of the processor module.
// Assumes all pin inputs are asynchronous to clk_i and that processor
// strobes and the trap level come from logic on clk_i.
//
// Functional notes
// - Retention strap keeps all elements; otherwise only flags 765 to 999.
// - Tick is 0.1 s with time-base strap fitted, 0.01 s removed.
// - Data-block strap fitted makes all 32 data blocks volatile.
// - Text and data share 8K bytes; area straps map parts to data socket.
// - Text or data socket may serve program lines 4096 to 8191.
// - Program and text socket writes pass only with write strap fitted.
// - Data socket writes always pass.
// - Legacy battery RAM write line ignores the write strap.
// - Run lamp toggles every 2 s, or every 0.2 s on fast base.
// - Run lamp holds its level in reset mode or on a trap.
// - Error lamp lights on a serial transmission error.
// - With no programming unit attached the mode is always run.
`timescale 1ns/10ps

module sci_strap_ctrl #(
  parameter int TICK_SLOW_CYC = sci_pkg::SCI_TICK_SLOW_CYC,
  parameter int TICK_FAST_CYC = sci_pkg::SCI_TICK_FAST_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Board straps and front panel, asynchronous
  input wire sci_pkg::sci_straps_s straps_i,
  input wire logic [1:0] mode_switch_i,
  input wire logic programming_unit_port_present_i,
  input wire logic serial_err_i,
  // Processor side
  input wire logic trap_i,
  input wire sci_pkg::sci_wr_s wr_req_i,
  input wire logic [12:0] text_data_addr_i,
  input wire logic [12:0] program_memory_socket_line_i,
  input wire logic [9:0] elem_addr_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Memory control
  output sci_pkg::sci_wr_s wr_o,
  output logic data_sock_sel_o,
  output logic [1:0] program_memory_socket_sock_o,
  output logic elem_retain_o,
  output logic retain_all_o,
  output logic dblock_volatile_o,
  // Mode and lamps
  output sci_pkg::sci_mode_e eff_mode_o,
  output logic tick_o,
  output logic run_led_o,
  output logic err_led_o
);

  // Share of the text/data space given to the data socket
  function automatic logic [13:0] area_base(input logic [1:0] sel);
    case (sel)
      2'h0: area_base = sci_pkg::SCI_AREA_NONE;
      2'h1: area_base = sci_pkg::SCI_AREA_QUARTER;
      2'h2: area_base = sci_pkg::SCI_AREA_HALF;
      default: area_base = sci_pkg::SCI_AREA_ALL;
    endcase
  endfunction : area_base

  // Tick period in cycles, less one, for the selected time base
  function automatic logic [sci_pkg::SCI_TICK_W-1:0] tick_len(
    input logic slow
  );
    if (slow) begin
      tick_len = sci_pkg::SCI_TICK_W'(TICK_SLOW_CYC - 1);
    end else begin
      tick_len = sci_pkg::SCI_TICK_W'(TICK_FAST_CYC - 1);
    end
  endfunction : tick_len

  // Pin capture and synchroniser stages
  logic [10:0] pin_raw;
  logic [10:0] pin_s1_reg;
  logic [10:0] pin_s2_reg;
  logic [10:0] pin_s3_reg;
  logic [10:0] pin_reg;
  // Accepted pin values, split by field
  sci_pkg::sci_straps_s strap_q;
  logic [1:0] switch_q;
  logic unit_q;
  logic ser_err_q;
  logic ser_err_prev_reg;
  // Time base and run lamp state
  logic tb_slow_reg;
  logic [sci_pkg::SCI_TICK_W-1:0] tick_cnt_reg;
  logic tick_now;
  logic [4:0] led_cnt_reg;
  logic [31:0] tick_total_reg;
  // Register side state
  logic halt_reg;
  logic err_flag_reg;
  sci_pkg::sci_mode_e mode_now;
  logic led_hold;
  logic [31:0] rd_word;

  assign pin_raw = {straps_i, mode_switch_i,
                    programming_unit_port_present_i, serial_err_i};

  // three-stage synchronisers
  // Reset value is the idle pin level, so no false error edge follows
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_s1_reg <= sci_pkg::SCI_PIN_RST;
      pin_s2_reg <= sci_pkg::SCI_PIN_RST;
      pin_s3_reg <= sci_pkg::SCI_PIN_RST;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // accept when stages agree
  // A bit moves only when stages two and three match, so a single
  // metastable sample never reaches the decode logic.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_reg <= sci_pkg::SCI_PIN_RST;
    end else begin
      pin_reg <= (pin_s2_reg & pin_s3_reg) |
                 (pin_reg & (pin_s2_reg | pin_s3_reg));
    end
  end

  assign strap_q = pin_reg[10:4];
  assign switch_q = pin_reg[3:2];
  assign unit_q = pin_reg[1];
  assign ser_err_q = pin_reg[0];

  assign mode_now = unit_q ? sci_pkg::sci_mode_e'(switch_q)
                           : sci_pkg::SCI_MODE_RUN;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      eff_mode_o <= sci_pkg::SCI_MODE_RUN;
    end else begin
      eff_mode_o <= mode_now;
    end
  end

  assign tick_now = (tick_cnt_reg == tick_len(tb_slow_reg));

  // Tick counter; restarts at each tick
  // Starts from zero, so the first tick after reset is a full period
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tick_cnt_reg <= '0;
    end else if (tick_now) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // base change taken on tick
  // Switching mid-period would give one runt or stretched tick.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      // Slow base until the first tick; a fast strap waits one slow period
      tb_slow_reg <= sci_pkg::SCI_TB_SLOW_RST;
    end else if (tick_now) begin
      tb_slow_reg <= strap_q.time_base_strap;
    end
  end

  // Tick pulse and running total for software
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tick_o <= 1'b0;
      tick_total_reg <= '0;
    end else begin
      tick_o <= tick_now;
      if (tick_now) begin
        tick_total_reg <= tick_total_reg + 1'b1;
      end
    end
  end

  // hold in reset mode or trap
  // trap_i is same-clock logic, so it bypasses the synchronisers
  assign led_hold = (mode_now == sci_pkg::SCI_MODE_RESET) | trap_i |
                    halt_reg;

  // toggle every twenty ticks
  // Twenty ticks give 2 s on the slow base and 0.2 s on the fast one.
  // The count is kept through a hold, so a resumed lamp keeps its phase.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      led_cnt_reg <= '0;
      run_led_o <= sci_pkg::SCI_LED_RST;
    end else if (tick_now && !led_hold) begin
      if (led_cnt_reg == 5'(sci_pkg::SCI_LED_TICKS - 1)) begin
        led_cnt_reg <= '0;
        run_led_o <= ~run_led_o;
      end else begin
        led_cnt_reg <= led_cnt_reg + 1'b1;
      end
    end
  end

  // Edge memory for the serial error level
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ser_err_prev_reg <= 1'b0;
    end else begin
      ser_err_prev_reg <= ser_err_q;
    end
  end

  // sticky error, set beats clear
  // A short error pulse stays visible until software clears it
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      err_flag_reg <= 1'b0;
    end else if (ser_err_q && !ser_err_prev_reg) begin
      err_flag_reg <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == sci_pkg::SCI_REG_CTRL &&
                 reg_wdata_i[sci_pkg::SCI_CTRL_ERRCLR_BIT]) begin
      err_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      err_led_o <= 1'b0;
    end else begin
      err_led_o <= err_flag_reg | ser_err_q;
    end
  end

  // Software halt of the run lamp
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      halt_reg <= sci_pkg::SCI_CTRL_HALT_RST;
    end else if (reg_wr_i && reg_addr_i == sci_pkg::SCI_REG_CTRL) begin
      halt_reg <= reg_wdata_i[sci_pkg::SCI_CTRL_HALT_BIT];
    end
  end

  // Write strobe gating, one cycle of latency
  // A strap pulled mid-write cuts the strobe; software must not rely on it
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_o <= '0;
    end else begin
      wr_o.program_memory_socket <= wr_req_i.program_memory_socket &
                                    strap_q.write_en_strap;
      wr_o.text_socket <= wr_req_i.text_socket & strap_q.write_en_strap;
      wr_o.data_socket <= wr_req_i.data_socket;
      wr_o.legacy_ram <= wr_req_i.legacy_ram;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      data_sock_sel_o <= 1'b0;
    end else begin
      data_sock_sel_o <= ({1'b0, text_data_addr_i} >=
                          area_base(strap_q.area_sel));
    end
  end

  // upper program lines on text or data
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      program_memory_socket_sock_o <= sci_pkg::SCI_SOCK_PROGRAM;
    end else if (program_memory_socket_line_i < sci_pkg::SCI_UPPER_PROGRAM_MEMORY_SOCKET_BASE) begin
      program_memory_socket_sock_o <= sci_pkg::SCI_SOCK_PROGRAM;
    end else if (strap_q.upper_on_data) begin
      program_memory_socket_sock_o <= sci_pkg::SCI_SOCK_DATA;
    end else begin
      program_memory_socket_sock_o <= sci_pkg::SCI_SOCK_TEXT;
    end
  end

  // Retention and volatility outputs
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      elem_retain_o <= 1'b0;
      retain_all_o <= 1'b0;
      dblock_volatile_o <= sci_pkg::SCI_DBLOCK_VOL_RST;
    end else begin
      retain_all_o <= strap_q.retention_strap;
      elem_retain_o <= strap_q.retention_strap |
                       (elem_addr_i >= sci_pkg::SCI_RETAIN_LO &&
                        elem_addr_i <= sci_pkg::SCI_RETAIN_HI);
      dblock_volatile_o <= strap_q.dblock_vol_strap;
    end
  end

  // Read mux; unmapped offsets read zero
  // Status shows the accepted straps, not the raw pin levels
  always_comb begin
    rd_word = '0;
    case (reg_addr_i)
      sci_pkg::SCI_REG_CTRL: begin
        rd_word[sci_pkg::SCI_CTRL_HALT_BIT] = halt_reg;
      end
      sci_pkg::SCI_REG_STATUS: begin
        rd_word[6:0] = strap_q;
        rd_word[8:7] = mode_now;
        rd_word[9] = unit_q;
        rd_word[10] = err_flag_reg;
        rd_word[11] = run_led_o;
        rd_word[12] = tb_slow_reg;
      end
      sci_pkg::SCI_REG_TICKS: begin
        rd_word = tick_total_reg;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_word;
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule : sci_strap_ctrl

// File: sci_strap_ctrl_assertions.sv
// Checker for the strap, gating, mode and lamp outputs.
// Sees only top ports; bound below with the design's own tick lengths.
`timescale 1ns/10ps
module sci_strap_ctrl_assertions #(
  parameter int TICK_SLOW_CYC = sci_pkg::SCI_TICK_SLOW_CYC,
  parameter int TICK_FAST_CYC = sci_pkg::SCI_TICK_FAST_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Inputs
  input wire sci_pkg::sci_straps_s straps_i,
  input wire logic programming_unit_port_present_i,
  input wire logic serial_err_i,
  input wire logic trap_i,
  input wire sci_pkg::sci_wr_s wr_req_i,
  input wire logic [12:0] program_memory_socket_line_i,
  input wire logic [9:0] elem_addr_i,
  input wire logic reg_rd_i,
  // Outputs
  input wire logic [31:0] reg_rdata_o,
  input wire sci_pkg::sci_wr_s wr_o,
  input wire logic [1:0] program_memory_socket_sock_o,
  input wire logic elem_retain_o,
  input wire logic retain_all_o,
  input wire sci_pkg::sci_mode_e eff_mode_o,
  input wire logic tick_o,
  input wire logic run_led_o,
  input wire logic err_led_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Cycles since last tick; first period after reset counts one cycle more
  int gap_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || tick_o) begin
      gap_reg <= 0;
    end else begin
      gap_reg <= gap_reg + 1;
    end
  end
  a_tick_period: assert property (tick_o |-> gap_reg inside
    {[TICK_FAST_CYC-2:TICK_FAST_CYC], [TICK_SLOW_CYC-2:TICK_SLOW_CYC]})
    else $error("tick spacing off");
  a_data_open: assert property (wr_o.data_socket ==
    $past(wr_req_i.data_socket)) else $error("data write lost");
  a_legacy_open: assert property (wr_o.legacy_ram ==
    $past(wr_req_i.legacy_ram)) else $error("legacy write lost");
  a_write_guard: assert property (!straps_i.write_en_strap [*8]
    |=> !wr_o.program_memory_socket && !wr_o.text_socket)
    else $error("protected write passed");
  a_upper_lines: assert property (1'b1 |=>
    ((program_memory_socket_sock_o == sci_pkg::SCI_SOCK_PROGRAM) ==
    ($past(program_memory_socket_line_i) < 13'h1000))) else $error("line socket wrong");
  a_retain_all: assert property (retain_all_o && $past(retain_all_o)
    |-> elem_retain_o) else $error("element not retained");
  a_mode_run: assert property (!programming_unit_port_present_i [*8]
    |=> eff_mode_o == sci_pkg::SCI_MODE_RUN) else $error("mode not run");
  a_err_lamp: assert property (serial_err_i [*8] |=> err_led_o)
    else $error("error lamp dark");
  a_lamp_hold: assert property (trap_i |=> $stable(run_led_o))
    else $error("lamp moved in hold");
  a_lamp_reset: assert property (eff_mode_o ==
    sci_pkg::SCI_MODE_RESET |-> $stable(run_led_o))
    else $error("lamp moved in reset mode");
  a_lamp_tick: assert property ($changed(run_led_o) |->
    tick_o) else $error("lamp moved off tick");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 0)
    else $error("read data without read");
endmodule : sci_strap_ctrl_assertions
bind sci_strap_ctrl sci_strap_ctrl_assertions #(
  .TICK_SLOW_CYC(TICK_SLOW_CYC),
  .TICK_FAST_CYC(TICK_FAST_CYC)
) i_chk (.*);

// File: sci_panel_model.sv
// Programming unit and serial peripheral at the panel side.
// Assumes the bench commands plug and line faults on clk_i.
`timescale 1ns/10ps
module sci_panel_model (
  // Clock and commands
  input wire logic clk_i,
  input wire logic attach_i,
  input wire logic fault_i,
  // Panel pins
  output logic present_o,
  output logic serr_o
);
  // Pins follow commands one edge late, like a cable being plugged
  initial begin
    present_o = 1'b0;
    serr_o = 1'b0;
  end
  always @(posedge clk_i) begin
    present_o <= attach_i;
    serr_o <= fault_i;
  end
endmodule : sci_panel_model

// File: sci_strap_ctrl_bench.sv
// Self-checking bench for sci_strap_ctrl and the panel model.
// Assumes tick lengths cut to 50 and 5 cycles at 100 MHz.
`timescale 1ns/10ps
module sci_strap_ctrl_bench;
  localparam int SLOW = 50;
  localparam int FAST = 5;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  sci_pkg::sci_straps_s straps_i = '0;
  sci_pkg::sci_straps_s s;
  logic [1:0] mode_switch_i = 2'h0;
  logic attach = 1'b0;
  logic fault = 1'b0;
  logic trap_i = 1'b0;
  sci_pkg::sci_wr_s wr_req_i = '0;
  logic [12:0] td = 13'h0000;
  logic [12:0] line = 13'h0000;
  logic [9:0] elem = 10'h000;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic present, serr, dsel, eret, rall, dvol, tick, led, eled;
  logic [31:0] rdata, rd, t0;
  logic [1:0] psock;
  sci_pkg::sci_wr_s wr_o;
  sci_pkg::sci_mode_e mode;
  logic [13:0] bases [4] = '{sci_pkg::SCI_AREA_NONE,
    sci_pkg::SCI_AREA_QUARTER, sci_pkg::SCI_AREA_HALF, sci_pkg::SCI_AREA_ALL};
  int mismatches = 0;
  int checked = 0;
  int tc = 0;
  int tc0;
  int seed, i, j, n;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) tc <= tc + (tick === 1'b1);
  sci_strap_ctrl #(.TICK_SLOW_CYC(SLOW), .TICK_FAST_CYC(FAST)) i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .straps_i(straps_i),
    .mode_switch_i(mode_switch_i),
    .programming_unit_port_present_i(present), .serial_err_i(serr),
    .trap_i(trap_i), .wr_req_i(wr_req_i), .text_data_addr_i(td),
    .program_memory_socket_line_i(line), .elem_addr_i(elem), .reg_addr_i(ra),
    .reg_wdata_i(wd), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdata),
    .wr_o(wr_o), .data_sock_sel_o(dsel), .program_memory_socket_sock_o(psock),
    .elem_retain_o(eret), .retain_all_o(rall), .dblock_volatile_o(dvol),
    .eff_mode_o(mode), .tick_o(tick), .run_led_o(led), .err_led_o(eled));
  sci_panel_model i_panel (.clk_i(clk_i), .attach_i(attach),
    .fault_i(fault), .present_o(present), .serr_o(serr));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc
  // One register access; read word sampled in the cycle after
  task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rwr <= w;
    rrd <= !w;
    ra <= a;
    wd <= d;
    @(posedge clk_i);
    rwr <= 1'b0;
    rrd <= 1'b0;
    #1 rd = rdata;
  endtask : rw
  // Random strobes and addresses against the gating model
  task automatic mem_step();
    sci_pkg::sci_wr_s w = 4'($urandom);
    logic [12:0] a = 13'($urandom);
    logic [12:0] l = 13'($urandom);
    logic [9:0] e = 10'($urandom_range(700, 1023));
    @(posedge clk_i);
    wr_req_i <= w;
    td <= a;
    line <= l;
    elem <= e;
    @(posedge clk_i);
    #1;
    chk("wr", wr_o, {w[3:2] & {2{s.write_en_strap}}, w[1:0]});
    chk("dsel", dsel, {1'b0, a} >= bases[s.area_sel]);
    chk("psock", psock, l < 13'h1000 ? sci_pkg::SCI_SOCK_PROGRAM :
      s.upper_on_data ? sci_pkg::SCI_SOCK_DATA : sci_pkg::SCI_SOCK_TEXT);
    chk("eret", eret, s.retention_strap | (e >= 765 && e <= 999));
  endtask : mem_step
  // Cycles between two lamp changes, capped at 3000
  task automatic period(output int p);
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = led;
      p = 0;
      while (led === v && p < 3000) begin
        @(posedge clk_i);
        #1 p++;
      end
    end
  endtask : period
  initial begin
    cyc(40000);
    mismatches++;
    summarize();
  end
  initial begin
    seed = $urandom(24);
    cyc(6);
    rst_b_i <= 1'b1;
    for (i = 0; i < 16; i++) begin
      s = 7'($urandom);
      s[3:0] = i[3:0];
      straps_i <= s;
      cyc(6);
      chk("rall", rall, s.retention_strap);
      chk("dvol", dvol, s.dblock_vol_strap);
      for (j = 0; j < 8; j++) mem_step();
    end
    for (i = 0; i < 8; i++) begin
      attach <= i[2];
      mode_switch_i <= i[1:0];
      cyc(8);
      chk("mode", mode, i[2] ? i[1:0] : 2'h0);
      rw(1'b0, sci_pkg::SCI_REG_STATUS, 32'h0);
      chk("status", rd[10:0], {1'b0, i[2], i[2] ? i[1:0] : 2'h0, s});
    end
    fault <= 1'b1;
    cyc(8);
    chk("eled", eled, 1'b1);
    fault <= 1'b0;
    cyc(8);
    rw(1'b0, 4'hc, 32'h0);
    chk("unmapped", rd, 32'h0);
    rw(1'b1, sci_pkg::SCI_REG_CTRL, 32'h2);
    cyc(2);
    chk("eled clr", eled, 1'b0);
    attach <= 1'b0;
    s.time_base_strap = 1'b1;
    straps_i <= s;
    cyc(60);
    period(n);
    chk("slow led", n, 20 * SLOW);
    s.time_base_strap = 1'b0;
    straps_i <= s;
    cyc(60);
    period(n);
    chk("fast led", n, 20 * FAST);
    rw(1'b0, sci_pkg::SCI_REG_TICKS, 32'h0);
    t0 = rd;
    tc0 = tc;
    cyc(498);
    rw(1'b0, sci_pkg::SCI_REG_TICKS, 32'h0);
    chk("ticks", rd - t0, 500 / FAST);
    chk("tick pulses", tc - tc0, 500 / FAST);
    for (i = 0; i < 3; i++) begin
      @(posedge clk_i);
      trap_i <= (i == 0);
      attach <= (i == 1);
      mode_switch_i <= 2'h2;
      rw(1'b1, sci_pkg::SCI_REG_CTRL, {31'h0, i == 2});
      period(n);
      chk("held led", n, 3000);
    end
    summarize();
  end
endmodule : sci_strap_ctrl_bench
